// ==== hw/acr_host.v ====
/*
  Host controller for an 8-bit multi-channel sampling converter with a
  parallel read port. Drives convert-start, chip-select, read strobe and
  channel address; collects results.
  Assumes the converter's end-of-conversion and data pins arrive
  asynchronously and are synchronised here; one 200 MHz clock.
*/
`include "acr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module acr_host (
  // Clock and reset
  input  wire                      clk_sys_i,
  input  wire                      rst_i,
  // User request
  input  wire                      start_i,
  input  wire                      power_down_i,
  input  wire [`ACR_CHAN_W-1:0]    next_chan_i,
  output wire                      ready_o,
  // User result
  output reg  [`ACR_DATA_W-1:0]    result_q_o,
  output reg  [`ACR_CHAN_W-1:0]    result_chan_o,
  output reg                       result_valid_o,
  // Converter pins
  output reg                       convert_start_n_o,
  output reg                       chip_select_n_o,
  output reg                       read_n_o,
  output reg  [`ACR_CHAN_W-1:0]    channel_addr_o,
  input  wire                      eoc_n_i,
  input  wire [`ACR_DATA_W-1:0]    data_i
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_PWRUP = 7'h02;
  localparam [6:0] S_LOW   = 7'h04;
  localparam [6:0] S_WAIT  = 7'h08;
  localparam [6:0] S_READ  = 7'h10;
  localparam [6:0] S_HOLD  = 7'h20;
  localparam [6:0] S_GAP   = 7'h40;

  // Counts are worked out as integers, then cut to the counter width
  localparam integer CONV_CYC_I   = `ACR_CONV_CYC;
  localparam integer SAMPLE_CYC_I = `ACR_SAMPLE_CYC;
  localparam integer SETTLE_CYC_I = `ACR_SETTLE_CYC;
  localparam integer START_CYC_I  = `ACR_START_CYC;
  localparam integer READ_CYC_I   = `ACR_READ_CYC;
  localparam integer PWRUP_CYC_I  = `ACR_POWERUP_CYC;

  localparam [`ACR_CNT_W-1:0] CONV_CYC   = CONV_CYC_I[`ACR_CNT_W-1:0];
  localparam [`ACR_CNT_W-1:0] SAMPLE_CYC = SAMPLE_CYC_I[`ACR_CNT_W-1:0];
  localparam [`ACR_CNT_W-1:0] SETTLE_CYC = SETTLE_CYC_I[`ACR_CNT_W-1:0];
  localparam [`ACR_CNT_W-1:0] START_CYC  = START_CYC_I[`ACR_CNT_W-1:0];
  localparam [`ACR_CNT_W-1:0] READ_CYC   = READ_CYC_I[`ACR_CNT_W-1:0];
  localparam [`ACR_CNT_W-1:0] PWRUP_CYC  = PWRUP_CYC_I[`ACR_CNT_W-1:0];

  reg [6:0]             state_q;
  reg [`ACR_CNT_W-1:0]  cnt_q;
  reg                   pd_mode_q;
  reg                   asleep_q;
  reg                   eoc_meta_q;
  reg                   eoc_sync_q;
  reg [`ACR_DATA_W-1:0] data_meta_q;
  reg [`ACR_DATA_W-1:0] data_sync_q;

  // Start is ignored outside idle; ready_o is high only in idle
  assign ready_o = state_q[0];

  // ----------------------------------------------------------------
  // Counter compare
  // ----------------------------------------------------------------
  // True on the last cycle of a phase that lasts lim cycles
  function cnt_at;
    input [`ACR_CNT_W-1:0] cnt;
    input [`ACR_CNT_W-1:0] lim;
    cnt_at = (cnt >= lim - 8'h01);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      // Idle levels, so reset gives no false end-of-conversion
      eoc_meta_q  <= 1'b1;
      eoc_sync_q  <= 1'b1;
      data_meta_q <= 8'h00;
      data_sync_q <= 8'h00;
    end else begin
      eoc_meta_q  <= eoc_n_i;
      eoc_sync_q  <= eoc_meta_q;
      data_meta_q <= data_i;
      data_sync_q <= data_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q           <= S_IDLE;
      cnt_q             <= 8'h00;
      pd_mode_q         <= 1'b0;
      // Device comes up from supply in low-current mode
      asleep_q          <= 1'b1;
      convert_start_n_o <= 1'b1;
      chip_select_n_o   <= 1'b1;
      read_n_o          <= 1'b1;
      channel_addr_o    <= 3'h0;
      result_q_o        <= 8'h00;
      result_chan_o     <= 3'h0;
      result_valid_o    <= 1'b0;
    end else begin
      result_valid_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          cnt_q <= 8'h00;
          if (start_i) begin
            pd_mode_q <= power_down_i;
            if (asleep_q) begin
              // Rising edge already sits on the pin; wait out power-up
              state_q <= S_PWRUP;
            end else begin
              convert_start_n_o <= 1'b0;
              state_q           <= S_LOW;
            end
          end
        end
        S_PWRUP: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_at(cnt_q, PWRUP_CYC)) begin
            asleep_q          <= 1'b0;
            cnt_q             <= 8'h00;
            convert_start_n_o <= 1'b0;
            state_q           <= S_LOW;
          end
        end
        S_LOW: begin
          cnt_q <= cnt_q + 8'h01;
          // High speed: rise long before end-of-conversion falls
          if (!pd_mode_q && cnt_at(cnt_q, START_CYC)) begin
            convert_start_n_o <= 1'b1;
          end
          // Power-down: keep low past the sampling point, then the low
          // pulse ends well short of power-up time
          if (pd_mode_q && cnt_at(cnt_q, SAMPLE_CYC)) begin
            asleep_q <= 1'b1;
          end
          if (cnt_at(cnt_q, CONV_CYC)) begin
            cnt_q <= 8'h00;
            // Address settles a cycle before the read strobe falls
            channel_addr_o <= next_chan_i;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Result is held in the output register; read at any time
          chip_select_n_o <= 1'b0;
          read_n_o        <= 1'b0;
          state_q         <= S_READ;
        end
        S_READ: begin
          cnt_q <= cnt_q + 8'h01;
          // Data pins pass two flops, so wait for them before sampling
          if (cnt_q >= READ_CYC + 8'h01) begin
            result_q_o      <= data_sync_q;
            result_chan_o   <= channel_addr_o;
            result_valid_o  <= 1'b1;
            read_n_o        <= 1'b1;
            chip_select_n_o <= 1'b1;
            cnt_q           <= 8'h00;
            state_q         <= S_GAP;
          end
        end
        S_GAP: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_at(cnt_q, SETTLE_CYC)) begin
            cnt_q   <= 8'h00;
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          // Raise convert-start only once end-of-conversion is high again,
          // which in power-down mode is the wake edge
          if (eoc_sync_q) begin
            convert_start_n_o <= 1'b1;
            state_q           <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== hw/acr_defines.vh ====
/*
  Timing constants for the sampling-converter host controller.
  Assumes a 200 MHz system clock; times are in ns.
*/
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

`define ACR_CLK_PERIOD_NS    5
// Conversion time, worst case
`define ACR_CONV_MAX_NS      420
// End-of-conversion low, worst case
`define ACR_EOC_MAX_NS       110
// Mode sampling point after convert-start fall, worst case
`define ACR_MODE_SAMPLE_NS   530
// Settling after a read before the next start in high-speed mode
`define ACR_SETTLE_NS        30
// Power-up time with external reference
`define ACR_POWERUP_NS       1000
// Convert-start low pulse width in high-speed mode
`define ACR_START_LOW_NS     50
// Read strobe low width
`define ACR_READ_LOW_NS      20

// All times round up except power-up, which rounds down
`define ACR_CYC_UP(ns)   (((ns) + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
`define ACR_CONV_CYC     `ACR_CYC_UP(`ACR_CONV_MAX_NS + `ACR_EOC_MAX_NS)
`define ACR_SAMPLE_CYC   `ACR_CYC_UP(`ACR_MODE_SAMPLE_NS)
`define ACR_SETTLE_CYC   `ACR_CYC_UP(`ACR_SETTLE_NS)
`define ACR_POWERUP_CYC  (`ACR_POWERUP_NS / `ACR_CLK_PERIOD_NS)
`define ACR_START_CYC    `ACR_CYC_UP(`ACR_START_LOW_NS)
`define ACR_READ_CYC     `ACR_CYC_UP(`ACR_READ_LOW_NS)

`define ACR_CNT_W        8
`define ACR_DATA_W       8
`define ACR_CHAN_W       3

`endif

// ==== bench/acr_dev_model.sv ====
/* Behavioural model of the sampling converter seen by acr_host.
   Assumes an external reference; times in ns, the slow case except a 100 ns end-of-conversion low. */
`timescale 1ns/1ps
`default_nettype none
module acr_dev_model (
  // Host side pins
  input  wire logic       convert_start_n_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       read_n_i,
  input  wire logic [2:0] channel_addr_i,
  // Converter outputs
  output logic            eoc_n_o,
  output logic [7:0]      data_o
);
  logic [7:0] out_q = 8'h00;
  logic [2:0] next_q = 3'h0;
  logic [4:0] seq_q = 5'h00;
  logic       asleep = 1'b1;
  realtime    up_t = 1000;
  initial eoc_n_o = 1'b1;
  always @(posedge convert_start_n_i) if (asleep) begin
    asleep = 1'b0;
    up_t = $realtime + 1000;
  end
  // Either strobe may update last within the same step; latch once both are low
  always @(negedge read_n_i or negedge chip_select_n_i)
    if (!read_n_i && !chip_select_n_i) next_q = channel_addr_i;
  always @(posedge read_n_i) eoc_n_o = 1'b1;
  always @(negedge convert_start_n_i) begin
    if ($realtime < up_t) #(up_t - $realtime);
    #420;
    seq_q = seq_q + 5'h01;
    out_q = {next_q, seq_q};
    eoc_n_o = 1'b0;
    #100 eoc_n_o = 1'b1;
    if (!convert_start_n_i) asleep = 1'b1;
  end
  // Deselected lines show the inverse so a stale sample cannot match
  assign data_o = (!chip_select_n_i && !read_n_i) ? out_q : ~out_q;
endmodule
`default_nettype wire

// ==== bench/acr_host_sva.sv ====
/* Checker on the acr_host ports, bound below.
   Assumes a 200 MHz clock and the converter model on the pins. */
`timescale 1ns/1ps
`default_nettype none
module acr_host_sva (
  // Clock, reset, user side
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       start_i,
  input wire logic       ready_o,
  input wire logic       result_valid_o,
  // Converter pins
  input wire logic       convert_start_n_o,
  input wire logic       chip_select_n_o,
  input wire logic       read_n_o,
  input wire logic       eoc_n_i,
  input wire logic [2:0] channel_addr_o
);
  // Cycles since the last convert-start fall, saturating
  logic [7:0] since_q;
  always @(posedge clk_sys_i)
    if (rst_i || $fell(convert_start_n_o)) since_q <= 8'h00;
    else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_cs_rd; !read_n_o |-> !chip_select_n_o; endproperty
  a_cs_rd: assert property (p_cs_rd) else $error("read without select");
  property p_rd_w; $fell(read_n_o) |-> !read_n_o [*4]; endproperty
  a_rd_w: assert property (p_rd_w) else $error("read strobe too short");
  property p_conv; $fell(read_n_o) |-> since_q >= 8'h54; endproperty
  a_conv: assert property (p_conv) else $error("read before conversion end");
  property p_hs; $rose(convert_start_n_o) && since_q < 8'h14 |-> eoc_n_i; endproperty
  a_hs: assert property (p_hs) else $error("late rise in high speed");
  property p_pd; $rose(convert_start_n_o) && since_q >= 8'h14 |-> since_q >= 8'h6A && eoc_n_i; endproperty
  a_pd: assert property (p_pd) else $error("power-down low too short");
  property p_pulse; !convert_start_n_o && !$past(convert_start_n_o) |-> since_q < 8'hC8; endproperty
  a_pulse: assert property (p_pulse) else $error("low pulse over power-up");
  property p_settle; $rose(read_n_o) |-> (!$fell(convert_start_n_o)) [*6]; endproperty
  a_settle: assert property (p_settle) else $error("start too soon after read");
  property p_valid; $rose(read_n_o) |-> result_valid_o; endproperty
  a_valid: assert property (p_valid) else $error("no result at read end");
  property p_addr; !read_n_o && !$past(read_n_o) |-> $stable(channel_addr_o); endproperty
  a_addr: assert property (p_addr) else $error("address moved in read");
  property p_start; start_i && ready_o |-> ##[1:210] $fell(convert_start_n_o); endproperty
  a_start: assert property (p_start) else $error("start not issued");
  c_hs: cover property ($rose(convert_start_n_o) && since_q < 8'h14);
  c_pd: cover property ($rose(convert_start_n_o) && since_q >= 8'h14);
  c_valid: cover property (result_valid_o);
endmodule
bind acr_host acr_host_sva u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i),
  .ready_o(ready_o), .result_valid_o(result_valid_o), .convert_start_n_o(convert_start_n_o),
  .chip_select_n_o(chip_select_n_o), .read_n_o(read_n_o), .eoc_n_i(eoc_n_i),
  .channel_addr_o(channel_addr_o));
`default_nettype wire

// ==== bench/tb.sv ====
/* Self-checking bench for acr_host with the converter model.
   Assumes the hw/ sources and both bench files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_sys_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, power_down_i = 1'b0;
  logic [2:0] next_chan_i = 3'h0, prev_ch = 3'h0, result_chan_o, channel_addr_o;
  logic [7:0] result_q_o, data_i;
  logic       ready_o, result_valid_o, convert_start_n_o, chip_select_n_o, read_n_o, eoc_n_i;
  logic [4:0] seq = 5'h00;
  int         mismatches = 0, checked = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  acr_host DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i), .power_down_i(power_down_i),
    .next_chan_i(next_chan_i), .ready_o(ready_o), .result_q_o(result_q_o), .result_chan_o(result_chan_o),
    .result_valid_o(result_valid_o), .convert_start_n_o(convert_start_n_o),
    .chip_select_n_o(chip_select_n_o), .read_n_o(read_n_o), .channel_addr_o(channel_addr_o),
    .eoc_n_i(eoc_n_i), .data_i(data_i));
  acr_dev_model u_dev (.convert_start_n_i(convert_start_n_o), .chip_select_n_i(chip_select_n_o),
    .read_n_i(read_n_o), .channel_addr_i(channel_addr_o), .eoc_n_o(eoc_n_i), .data_o(data_i));
  task chk(input logic ok, input string msg);
    checked++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // One conversion; latency counted from the edge that takes the start
  task conv(input logic pd, input logic [2:0] ch, input int lo, input int hi);
    int n;
    n = 0;
    do begin @(negedge clk_sys_i); n++; end while (ready_o !== 1'b1 && n < 400);
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    power_down_i <= pd;
    next_chan_i <= ch;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    n = 0;
    do begin @(negedge clk_sys_i); n++; end while (result_valid_o !== 1'b1 && n < 600);
    seq = seq + 5'h01;
    chk(n >= lo && n < hi, "latency");
    chk(result_q_o === {prev_ch, seq}, "result");
    chk(result_chan_o === ch, "channel");
    prev_ch = ch;
  endtask
  task t_idle;
    @(negedge clk_sys_i);
    chk(convert_start_n_o === 1'b1 && read_n_o === 1'b1 && chip_select_n_o === 1'b1, "idle pins");
    chk(ready_o === 1'b1, "ready");
  endtask
  task t_first;
    conv(1'b0, 3'h5, 307, 400);
  endtask
  task t_hop;
    for (int i = 0; i < 8; i++) conv(1'b0, 3'(i), 107, 200);
  endtask
  task t_pd;
    conv(1'b1, 3'h2, 107, 200);
    conv(1'b1, 3'h6, 307, 400);
    conv(1'b0, 3'h1, 307, 400);
  endtask
  task end_of_test;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_idle;
    t_first;
    t_hop;
    t_pd;
    end_of_test;
  end
  initial begin
    #60000;
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
